// *** src/rlic_ctrl.sv ***
`timescale 1ns/1ps
module rlic_ctrl
	import rlic_pkg::*;
#(
	parameter int INIT_CYC_P = INIT_CYC
) (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] mode_word,
	input  wire logic              dll_relock,
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire logic              req_write,
	input  wire logic [BA_W-1:0]   req_bank,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic              wd_valid,
	input  wire logic [DQ_W-1:0]   wd_data,
	output logic                   wd_ready,
	output logic                   ck,
	output logic                   ck_n,
	output logic                   dk,
	output logic                   dk_n,
	output logic                   cs_n,
	output logic                   we_n,
	output logic                   ref_n,
	output logic [BA_W-1:0]        ba,
	output logic [ADDR_W-1:0]      addr,
	output logic [DQ_W-1:0]        dq_out,
	output logic                   dq_oe,
	input  wire logic [DQ_W-1:0]   dq_in,
	output logic [DQ_W-1:0]        rd_data,
	output logic                   init_done
);
	localparam int WD_LAT = 2 * WL_CYC + 2;

	function automatic logic bank_free(input logic [RC_W-1:0] v);
		return (v == '0);
	endfunction

	rlic_state_t       state_q;
	rlic_state_t       state_d;
	logic              ck_q;
	logic              ck_n_q;
	logic              cs_n_q;
	logic              we_n_q;
	logic              ref_n_q;
	logic [BA_W-1:0]   ba_q;
	logic [ADDR_W-1:0] addr_q;
	logic [WAIT_W-1:0] wait_q;
	logic [1:0]        mrs_n_q;
	logic [3:0]        iref_q;
	logic [CNT_W-1:0]  nop_q;
	logic [CNT_W-1:0]  dll_q;
	logic [1:0]        gap_q;
	logic [RC_W-1:0]   rc_q [NBANK];
	logic [BA_W-1:0]   rbank_q;
	logic [7:0]        refi_q;
	logic [3:0]        owed_q;
	logic [1:0]        relock_q;
	logic              pend_q;
	logic              pend_wr_q;
	logic [BA_W-1:0]   pend_ba_q;
	logic [ADDR_W-1:0] pend_addr_q;
	logic              req_ready_q;
	logic [WL_CYC:0]   wpipe_q;
	logic              wb_q;
	logic [DQ_W-1:0]   dq_out_q;
	logic              dq_oe_q;
	logic [DQ_W-1:0]   dq_s1_q;
	logic [DQ_W-1:0]   dq_s2_q;
	logic              init_done_q;
	logic [WAIT_W-1:0] pwr_cnt_q;
	logic [2:0]        c_cmd;
	logic [BA_W-1:0]   c_ba;
	logic [ADDR_W-1:0] c_addr;
	logic              c_user;
	logic              c_dll_on;
	logic [DQ_W-1:0]   f_data;
	logic              f_valid;
	logic [4:0]        f_cnt;

	// decode of bank readiness, data supply and mode words
	wire              tick     = ck_q;
	wire [ADDR_W-1:0] dll_mask = ADDR_W'(1) << MODE_DLL_BIT;
	wire [ADDR_W-1:0] mode_on  = mode_word | dll_mask;
	wire [ADDR_W-1:0] mode_off = mode_word & ~dll_mask;
	wire [5:0] need = 6'(2 * $countones(wpipe_q)) + 6'd2 + {5'd0, wb_q};
	wire       wr_ok  = ({1'b0, f_cnt} >= need);
	wire       rd_ok  = (dll_q == '0) && (gap_q == '0);
	wire       ref_go = (owed_q != '0) && bank_free(rc_q[rbank_q]);
	wire       user_go = pend_q && bank_free(rc_q[pend_ba_q]) &&
	                     (pend_wr_q ? wr_ok : rd_ok);
	wire       accept = req_valid && req_ready_q;
	wire       pend_d = accept || (pend_q && !(tick && c_user));
	wire       pop = ((!tick && wpipe_q[WL_CYC]) || wb_q) && f_valid;
	wire [2:0] pin_cmd = {cs_n_q, we_n_q, ref_n_q};

	// registered outputs
	assign ck        = ck_q;
	assign ck_n      = ck_n_q;
	assign dk        = ck_q;
	assign dk_n      = ck_n_q;
	assign cs_n      = cs_n_q;
	assign we_n      = we_n_q;
	assign ref_n     = ref_n_q;
	assign ba        = ba_q;
	assign addr      = addr_q;
	assign dq_out    = dq_out_q;
	assign dq_oe     = dq_oe_q;
	assign rd_data   = dq_s2_q;
	assign req_ready = req_ready_q;
	assign init_done = init_done_q;

	// write data buffer; wd_ready stalls the source when full
	rlic_fifo #(.W(DQ_W), .D(FIFO_DEPTH)) u_wfifo (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.in_valid  (wd_valid),
		.in_data   (wd_data),
		.in_ready  (wd_ready),
		.out_valid (f_valid),
		.out_data  (f_data),
		.out_ready (pop),
		.count     (f_cnt)
	);

	// command choice for the next link cycle
	always_comb begin
		state_d  = state_q;
		c_cmd    = CMD_NOP;
		c_ba     = '0;
		c_addr   = '0;
		c_user   = 1'b0;
		c_dll_on = 1'b0;
		case (state_q)
		ST_POWER: begin
			if (wait_q == '0)
				state_d = ST_MODE;
		end
		ST_MODE: begin
			c_cmd = CMD_MRS;
			if (mrs_n_q == 2'(DUMMY_MRS)) begin
				c_addr   = mode_on;
				c_dll_on = 1'b1;
				state_d  = ST_SETTLE;
			end
		end
		ST_SETTLE: begin
			if (wait_q == '0)
				state_d = ST_INIT;
		end
		ST_INIT: begin
			if (iref_q < 4'(NBANK)) begin
				c_cmd = CMD_REF;
				c_ba  = iref_q[BA_W-1:0];
			end else if (nop_q == CNT_W'(INIT_NOPS)) begin
				state_d = ST_RUN;
			end
		end
		ST_RUN: begin
			if (relock_q == 2'd1) begin
				c_cmd  = CMD_MRS;
				c_addr = mode_off;
			end else if (relock_q == 2'd2) begin
				if (wait_q == '0) begin
					c_cmd    = CMD_MRS;
					c_addr   = mode_on;
					c_dll_on = 1'b1;
				end
			end else if (ref_go) begin
				c_cmd = CMD_REF;
				c_ba  = rbank_q;
			end else if (user_go) begin
				c_cmd  = pend_wr_q ? CMD_WR : CMD_RD;
				c_ba   = pend_ba_q;
				c_addr = pend_addr_q;
				c_user = 1'b1;
			end
		end
		default: state_d = ST_POWER;
		endcase
	end

	// link clock divider, running from reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ck_q   <= 1'b0;
			ck_n_q <= 1'b1;
		end else begin
			ck_q   <= ~ck_q;
			ck_n_q <= ck_q;
		end
	end

	// command pins change as ck falls, stable at its rise
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			{cs_n_q, we_n_q, ref_n_q} <= CMD_NOP;
			ba_q   <= '0;
			addr_q <= '0;
		end else if (tick) begin
			{cs_n_q, we_n_q, ref_n_q} <= c_cmd;
			ba_q   <= c_ba;
			addr_q <= c_addr;
		end
	end

	// sequencing state and initialization counters
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= ST_POWER;
			wait_q  <= WAIT_W'(INIT_CYC_P);
			mrs_n_q <= '0;
			iref_q  <= '0;
			nop_q   <= '0;
		end else if (tick) begin
			state_q <= state_d;
			if (c_dll_on || (relock_q == 2'd1))
				wait_q <= WAIT_W'(MRSC_CYC - 1);
			else if (wait_q != '0)
				wait_q <= wait_q - 1'b1;
			if (state_q == ST_MODE)
				mrs_n_q <= mrs_n_q + 1'b1;
			if (state_q == ST_INIT && c_cmd == CMD_REF)
				iref_q <= iref_q + 1'b1;
			if (state_q == ST_INIT && c_cmd == CMD_NOP &&
			    nop_q != CNT_W'(INIT_NOPS))
				nop_q <= nop_q + 1'b1;
		end
	end

	// per-bank row cycle counters
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int b = 0; b < NBANK; b++)
				rc_q[b] <= '0;
		end else if (tick) begin
			for (int b = 0; b < NBANK; b++) begin
				if (c_cmd != CMD_NOP && c_cmd != CMD_MRS &&
				    c_ba == BA_W'(b))
					rc_q[b] <= RC_W'(TRC_CYC - 1);
				else if (rc_q[b] != '0)
					rc_q[b] <= rc_q[b] - 1'b1;
			end
		end
	end

	// dll lock wait, write-to-read gap and relock phase
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dll_q    <= '0;
			gap_q    <= '0;
			relock_q <= '0;
		end else begin
			if (tick && c_dll_on)
				dll_q <= CNT_W'(DLL_CYC);
			else if (tick && dll_q != '0)
				dll_q <= dll_q - 1'b1;
			if (tick && c_cmd == CMD_WR)
				gap_q <= 2'(WR2RD_NOPS);
			else if (tick && gap_q != '0)
				gap_q <= gap_q - 1'b1;
			if (dll_relock && relock_q == 2'd0 && init_done_q)
				relock_q <= 2'd1;
			else if (tick && state_q == ST_RUN && relock_q == 2'd1)
				relock_q <= 2'd2;
			else if (tick && state_q == ST_RUN && c_dll_on)
				relock_q <= 2'd0;
		end
	end

	// periodic refresh, one bank at a time, round robin
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			refi_q  <= '0;
			owed_q  <= '0;
			rbank_q <= '0;
		end else if (tick && state_q == ST_RUN) begin
			if (refi_q == 8'(REFI_CYC - 1))
				refi_q <= '0;
			else
				refi_q <= refi_q + 1'b1;
			owed_q <= owed_q + 4'(refi_q == 8'(REFI_CYC - 1))
			          - 4'(c_cmd == CMD_REF);
			if (c_cmd == CMD_REF)
				rbank_q <= rbank_q + 1'b1;
		end
	end

	// one pending user request, taken when ready is high
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pend_q      <= 1'b0;
			pend_wr_q   <= 1'b0;
			pend_ba_q   <= '0;
			pend_addr_q <= '0;
			req_ready_q <= 1'b0;
			init_done_q <= 1'b0;
		end else begin
			pend_q      <= pend_d;
			req_ready_q <= (state_q == ST_RUN) && !pend_d;
			init_done_q <= (state_q == ST_RUN);
			if (accept) begin
				pend_wr_q   <= req_write;
				pend_ba_q   <= req_bank;
				pend_addr_q <= req_addr;
			end
		end
	end

	// write burst of two words, write latency after the command
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wpipe_q  <= '0;
			wb_q     <= 1'b0;
			dq_out_q <= '0;
			dq_oe_q  <= 1'b0;
		end else begin
			if (tick)
				wpipe_q <= {wpipe_q[WL_CYC-1:0], c_cmd == CMD_WR};
			wb_q    <= !tick && wpipe_q[WL_CYC]; // first word as dk rises
			dq_oe_q <= pop;
			if (pop)
				dq_out_q <= f_data;
		end
	end

	// read data pins into the system clock domain
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dq_s1_q <= '0;
			dq_s2_q <= '0;
		end else begin
			dq_s1_q <= dq_in;
			dq_s2_q <= dq_s1_q;
		end
	end

	// link cycles since reset, held at INIT_CYC_P, watched by a_wait below
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			pwr_cnt_q <= '0;
		else if (tick && pwr_cnt_q != WAIT_W'(INIT_CYC_P))
			pwr_cnt_q <= pwr_cnt_q + 1'b1;
	end

	property p_nop_power;
		@(posedge clk_sys) disable iff (rst)
		state_q == ST_POWER |-> pin_cmd == CMD_NOP;
	endproperty
	a_nop_power: assert property (p_nop_power)
		else $error("command pins not idle during power-up");

	property p_wait;
		@(posedge clk_sys) disable iff (rst)
		(tick && c_cmd == CMD_MRS) |-> pwr_cnt_q == WAIT_W'(INIT_CYC_P);
	endproperty
	a_wait: assert property (p_wait)
		else $error("mode set before stable time");

	property p_mrs_seq;
		@(posedge clk_sys) disable iff (rst)
		(tick && state_q == ST_MODE && mrs_n_q == 2'd0) |->
		c_cmd == CMD_MRS ##2 (tick && c_cmd == CMD_MRS && !c_dll_on)
		##2 (tick && c_cmd == CMD_MRS && c_dll_on);
	endproperty
	a_mrs_seq: assert property (p_mrs_seq)
		else $error("init mode sets not back to back");

	property p_settle;
		@(posedge clk_sys) disable iff (rst)
		(tick && state_q == ST_MODE && c_dll_on) |=>
		!(c_cmd == CMD_REF && tick) [*8] ##1
		!(c_cmd == CMD_REF && tick) [*3];
	endproperty
	a_settle: assert property (p_settle)
		else $error("refresh inside mode set settle time");

	property p_init_done;
		@(posedge clk_sys) disable iff (rst)
		(state_q == ST_RUN && $past(state_q) == ST_INIT) |->
		nop_q == CNT_W'(INIT_NOPS) && iref_q == 4'(NBANK);
	endproperty
	a_init_done: assert property (p_init_done)
		else $error("run entered before init refreshes and nops");

	property p_rc;
		@(posedge clk_sys) disable iff (rst)
		(tick && (c_cmd == CMD_RD || c_cmd == CMD_WR ||
		 c_cmd == CMD_REF)) |-> rc_q[c_ba] == '0;
	endproperty
	a_rc: assert property (p_rc)
		else $error("bank reused inside row cycle time");

	property p_wr_rd;
		@(posedge clk_sys) disable iff (rst)
		(tick && c_cmd == CMD_WR) |=> !(tick && c_cmd == CMD_RD) [*4];
	endproperty
	a_wr_rd: assert property (p_wr_rd)
		else $error("read too close after write");

	property p_dll;
		@(posedge clk_sys) disable iff (rst)
		(tick && c_cmd == CMD_RD) |-> dll_q == '0 && init_done_q;
	endproperty
	a_dll: assert property (p_dll)
		else $error("read before dll lock time");

	property p_ref_rate;
		@(posedge clk_sys) disable iff (rst)
		owed_q <= 4'd1;
	endproperty
	a_ref_rate: assert property (p_ref_rate)
		else $error("refresh falling behind");

	property p_wdata;
		@(posedge clk_sys) disable iff (rst)
		(tick && c_cmd == CMD_WR) |-> ##WD_LAT dq_oe_q ##1 dq_oe_q;
	endproperty
	a_wdata: assert property (p_wdata)
		else $error("write data not at write latency");

	property p_fifo;
		@(posedge clk_sys) disable iff (rst)
		(tick && c_cmd == CMD_WR) |-> f_cnt >= 5'd2;
	endproperty
	a_fifo: assert property (p_fifo)
		else $error("write issued without its data");
endmodule

// *** src/rlic_pkg.sv ***
package rlic_pkg;
	// system clock and link clock divider
	localparam int CLK_MHZ      = 200;
	localparam int LINK_DIV     = 2;
	localparam int LINK_MHZ     = CLK_MHZ / LINK_DIV;
	// power-up stable time, counted in link cycles
	localparam int T_INIT_US    = 200;
	localparam int INIT_CYC     = T_INIT_US * LINK_MHZ;
	// average refresh spacing, longest time so it rounds down
	localparam int T_REFI_NS    = 488;
	localparam int REFI_CYC     = T_REFI_NS * LINK_MHZ / 1000;
	// link cycles after the dll is enabled before a read
	localparam int DLL_CYC      = 1024;
	localparam int INIT_NOPS    = 1024;
	localparam int DUMMY_MRS    = 2;
	localparam int NBANK        = 8;
	localparam int BA_W         = 3;
	localparam int ADDR_W       = 20;
	localparam int DQ_W         = 18;
	localparam int CNT_W        = 11;
	localparam int RC_W         = 4;
	localparam int WAIT_W       = 16;
	// row cycle time and mode set settle time in link cycles
	localparam int TRC_CYC      = 4;
	localparam int MRSC_CYC     = 6;
	localparam int RL_CYC       = 4;
	localparam int WL_CYC       = RL_CYC + 1;
	localparam int WR2RD_NOPS   = 2;
	localparam int MODE_DLL_BIT = 7;
	localparam int FIFO_DEPTH   = 16;
	// command pins {cs_n, we_n, ref_n}
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_RD  = 3'h3;
	localparam logic [2:0] CMD_WR  = 3'h1;
	localparam logic [2:0] CMD_REF = 3'h2;
	typedef enum logic [4:0] {
		ST_POWER  = 5'h01,
		ST_MODE   = 5'h02,
		ST_SETTLE = 5'h04,
		ST_INIT   = 5'h08,
		ST_RUN    = 5'h10
	} rlic_state_t;
endpackage

// *** src/rlic_fifo.sv ***
`timescale 1ns/1ps
module rlic_fifo #(
	parameter int W = 18,
	parameter int D = 16
) (
	input  wire logic                     clk_sys,
	input  wire logic                     rst,
	input  wire logic                     in_valid,
	input  wire logic [W-1:0]             in_data,
	output logic                          in_ready,
	output logic                          out_valid,
	output logic [W-1:0]                  out_data,
	input  wire logic                     out_ready,
	output logic [$clog2(D):0]            count
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0]   cnt_q;
	logic [AW:0]   cnt_d;
	logic          nfull_q;
	wire           push = in_valid && nfull_q;
	wire           pop  = out_ready && (cnt_q != '0);

	// handshake views of the pointers
	assign in_ready  = nfull_q;
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem[rp_q];
	assign count     = cnt_q;
	assign cnt_d     = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	// storage has no reset
	always_ff @(posedge clk_sys) begin
		if (push)
			mem[wp_q] <= in_data;
	end

	// pointers, fill level and registered not-full
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wp_q    <= '0;
			rp_q    <= '0;
			cnt_q   <= '0;
			nfull_q <= 1'b1;
		end else begin
			wp_q    <= wp_q + AW'(push);
			rp_q    <= rp_q + AW'(pop);
			cnt_q   <= cnt_d;
			nfull_q <= (cnt_d != (AW+1)'(D));
		end
	end
endmodule

// *** dv/rlic_mem.sv ***
`timescale 1ns/1ps
module rlic_mem
	import rlic_pkg::*;
#(
	parameter int INIT_P = 20
) (
	input  wire logic              ck,
	input  wire logic              dk,
	input  wire logic              cs_n,
	input  wire logic              we_n,
	input  wire logic              ref_n,
	input  wire logic [BA_W-1:0]   ba,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DQ_W-1:0]   dq_out,
	input  wire logic              dq_oe,
	output logic      [DQ_W-1:0]   dq_in
);
	logic [2:0]        cmd;
	logic [NBANK-1:0]  init_ref = '0;
	logic [12:0]       row [NBANK] = '{default: '0};
	logic [DQ_W-1:0]   mem [NBANK][2];
	logic [DQ_W-1:0]   cap [$];
	logic [ADDR_W-1:0] mode_q;
	logic [BA_W-1:0]   rd_b = '0;
	logic [BA_W-1:0]   wb [$];
	int                wc [$];
	int                last [NBANK] = '{default: -99};
	int                cyc = 0, viol = 0, nops = 0, n_mrs = 0;
	int                mrs_at = 0, dll_at = 0, wr_at = -99, rd_at = -99;
	bit                run = 1'b0;

	assign cmd = {cs_n, we_n, ref_n};

	task automatic bad(input string s);
		viol++;
		$display("unexpected %0t model: %s", $time, s);
	endtask

	// decode a command at each link clock rise
	always @(posedge ck) begin
		cyc++;
		if (cmd != CMD_NOP && cmd != CMD_MRS) begin
			if ($isunknown(ba))
				bad("bank");
			// only the addressed bank is busy
			if (cyc - last[ba] < TRC_CYC)
				bad("row cycle");
			last[ba] = cyc;
			if (cmd != CMD_REF && !run) begin
				run = 1'b1;
				if (init_ref != '1 || nops < INIT_NOPS)
					bad("init");
			end
		end
		if (n_mrs == 0 && cmd != CMD_NOP && cmd != CMD_MRS)
			bad("power command");
		case (cmd)
			CMD_NOP: nops++;
			CMD_MRS: begin
				if (n_mrs == 0 && nops < INIT_P)
					bad("early mode set");
				// no settle needed between init mode sets
				if (n_mrs inside {[1:DUMMY_MRS]} && nops != 0)
					bad("mode sets apart");
				if (n_mrs < DUMMY_MRS && addr != '0)
					bad("dummy address");
				if (n_mrs >= DUMMY_MRS) begin
					mode_q = addr;
					mrs_at = cyc;
					dll_at = addr[MODE_DLL_BIT] ? cyc : 1 << 30;
				end
				n_mrs++;
				nops = 0;
			end
			CMD_REF: begin
				if (!run && cyc - mrs_at < MRSC_CYC)
					bad("settle");
				// row from the bank counter, address unused
				row[ba]++;
				init_ref[ba] = 1'b1;
			end
			CMD_WR: begin
				wc.push_back(cyc + WL_CYC);
				wb.push_back(ba);
				wr_at = cyc;
			end
			CMD_RD: begin
				if (cyc - wr_at <= WR2RD_NOPS)
					bad("write to read");
				if (cyc - dll_at < DLL_CYC)
					bad("dll lock");
				rd_at = cyc;
				rd_b = ba;
			end
			default: ;
		endcase
		dq_in <= cyc == rd_at + RL_CYC ? mem[rd_b][0] : ~dq_in;
	end

	// second read word, a toggling pattern while released
	initial dq_in = '0;
	always @(negedge ck)
		dq_in <= cyc == rd_at + RL_CYC ? mem[rd_b][1] : ~dq_in;

	// write data taken mid-way through each data clock phase
	always @(dk) begin
		#2.5;
		if (wc.size() != 0 && cyc == wc[0]) begin
			if (dq_oe !== 1'b1)
				bad("write data not driven");
			mem[wb[0]][!dk] = dq_out;
			cap.push_back(dq_out);
			if (!dk) begin
				void'(wc.pop_front());
				void'(wb.pop_front());
			end
		end
	end
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
	import rlic_pkg::*;
	localparam int                INIT_P = 20;
	localparam logic [ADDR_W-1:0] MODE   = 20'h00023;
	logic              clk_sys, rst, dll_relock, req_valid, req_ready;
	logic              req_write, wd_valid, wd_ready, ck, ck_n, dk, dk_n;
	logic              cs_n, we_n, ref_n, dq_oe, init_done;
	logic [BA_W-1:0]   req_bank, ba;
	logic [ADDR_W-1:0] mode_word, req_addr, addr;
	logic [DQ_W-1:0]   wd_data, dq_out, dq_in, rd_data;
	logic [DQ_W-1:0]   exp_q [$];
	int                fail_count = 0;
	int                n_compared = 0;

	rlic_ctrl #(.INIT_CYC_P(INIT_P)) rlic_ctrl_i (
		.clk_sys, .rst, .mode_word, .dll_relock, .req_valid, .req_ready,
		.req_write, .req_bank, .req_addr, .wd_valid, .wd_data, .wd_ready,
		.ck, .ck_n, .dk, .dk_n, .cs_n, .we_n, .ref_n, .ba, .addr,
		.dq_out, .dq_oe, .dq_in, .rd_data, .init_done
	);
	rlic_mem #(.INIT_P(INIT_P)) rlic_mem_i (
		.ck, .dk, .cs_n, .we_n, .ref_n, .ba, .addr, .dq_out, .dq_oe, .dq_in
	);

	// system clock
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic cmp_bit(input logic g, input logic e, input string s);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %0t %s: %b", $time, s, g);
		end
	endtask

	task automatic cmp_word(input logic [DQ_W-1:0] g, e, input string s);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %0t %s: %h not %h", $time, s, g, e);
		end
	endtask

	task automatic cmp_int(input int g, input int e, input string s);
		n_compared++;
		if (g != e) begin
			fail_count++;
			$display("unexpected %0t %s: %0d not %0d", $time, s, g, e);
		end
	endtask

	// offer a request and hold it until the edge that takes it
	task automatic req(input logic w, input logic [BA_W-1:0] b);
		int n;
		n = 0;
		req_valid <= 1'b1;
		req_write <= w;
		req_bank <= b;
		req_addr <= ADDR_W'(b) << 4;
		do begin
			@(posedge clk_sys);
			n++;
		end while (req_ready !== 1'b1 && n < 3000);
		cmp_bit(req_ready, 1'b1, "request taken");
		req_valid <= 1'b0;
		tick(1);
	endtask

	// stream n write words into the buffer, valid held throughout
	task automatic push(input int n, input logic [DQ_W-1:0] d);
		for (int i = 0; i < n; i++) begin
			wd_valid <= 1'b1;
			wd_data <= d + DQ_W'(i);
			exp_q.push_back(d + DQ_W'(i));
			do
				@(posedge clk_sys);
			while (wd_ready !== 1'b1);
		end
		wd_valid <= 1'b0;
		tick(1);
	endtask

	// captured write words against the pushed ones, in order
	task automatic chk_cap(input int n);
		for (int k = 0; k < 400 && rlic_mem_i.cap.size() < n; k++)
			tick(1);
		cmp_int(rlic_mem_i.cap.size(), n, "captured words");
		for (int i = 0; i < n; i++)
			cmp_word(rlic_mem_i.cap[i], exp_q[i], "write data");
		rlic_mem_i.cap.delete();
		exp_q.delete();
	endtask

	task automatic t_init();
		tick(20);
		cmp_bit(req_ready, 1'b0, "ready during init");
		cmp_bit(ck_n, !ck, "clock pair");
		cmp_bit(dk_n, !dk, "data clock pair");
		for (int n = 0; n < 6000 && init_done !== 1'b1; n++)
			tick(1);
		cmp_bit(init_done, 1'b1, "init done");
		cmp_int(rlic_mem_i.n_mrs, DUMMY_MRS + 1, "mode sets");
		cmp_int(int'(rlic_mem_i.mode_q), int'(MODE | 20'h00080), "mode");
		cmp_int(int'(rlic_mem_i.init_ref), 255, "init refresh");
		$display("test init done");
	endtask

	task automatic t_fifo();
		push(FIFO_DEPTH, 18'h10000);
		cmp_bit(wd_ready, 1'b0, "buffer full");
		for (int b = 0; b < NBANK; b++)
			req(1'b1, BA_W'(b));
		chk_cap(2 * NBANK);
		cmp_bit(wd_ready, 1'b1, "buffer drained");
		for (int b = 0; b < NBANK; b++)
			req(1'b0, BA_W'(b));
		tick(40);
		cmp_int(rlic_mem_i.viol, 0, "device timing");
		$display("test fifo done");
	endtask

	task automatic t_same();
		int n;
		push(4, 18'h2A000);
		req(1'b1, 3'h2);
		req(1'b1, 3'h2);
		req(1'b0, 3'h2);
		for (n = 0; n < 100 && rd_data !== 18'h2A002; n++)
			tick(1);
		cmp_word(rd_data, 18'h2A002, "read data");
		chk_cap(4);
		cmp_int(rlic_mem_i.viol, 0, "device timing");
		$display("test same bank done");
	endtask

	task automatic t_relock();
		int m;
		m = rlic_mem_i.n_mrs;
		dll_relock <= 1'b1;
		tick(1);
		dll_relock <= 1'b0;
		req(1'b0, 3'h5);
		tick(20);
		cmp_int(rlic_mem_i.n_mrs, m + 2, "relock mode sets");
		cmp_int(int'(rlic_mem_i.mode_q[MODE_DLL_BIT]), 1, "dll on");
		cmp_int(rlic_mem_i.viol, 0, "device timing");
		$display("test relock done");
	endtask

	task automatic t_refresh();
		int r;
		int c;
		r = rlic_mem_i.row.sum() with (int'(item));
		c = rlic_mem_i.cyc;
		tick(4000);
		r = rlic_mem_i.row.sum() with (int'(item)) - r;
		c = (rlic_mem_i.cyc - c) / REFI_CYC - 1;
		cmp_int(int'(r >= c), 1, "refresh rate");
		cmp_int(rlic_mem_i.viol, 0, "device timing");
		$display("test refresh done");
	endtask

	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// main sequence
	initial begin
		rst = 1'b1;
		mode_word = MODE;
		dll_relock = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_bank = '0;
		req_addr = '0;
		wd_valid = 1'b0;
		wd_data = '0;
		tick(10);
		rst <= 1'b0;
		t_init();
		t_fifo();
		t_same();
		t_relock();
		t_refresh();
		summarize();
	end

	// hang guard, about four and a half times the expected run
	initial begin
		#150000;
		fail_count++;
		summarize();
	end
endmodule
